//--- common/pse_pkg.sv
// How it works
// - Status general bit 3 shows external overheat live.
// - Status general bit 2 is high while the sequencer runs.
// - Status general bit 1 shows junction overheat live.
// - Status general bit 0 is 1 when supply is fine, 0 on fault.
// - Status short-circuit bits 3..5 show converter one..three shorts live.
// - Status timeout bits 3..5 show converter drop timeouts live.
// - Status timeout bits 1..0 show the two pin conditions.
// - Event general bit 3 sets on external overheat rising.
// - Event general bit 2 sets when a power-up sequence completes.
// - Event general bit 1 sets on junction overheat rising.
// - Event general bit 0 sets when supply drops below threshold.
// - Event short-circuit bits 3..5 set on debounced converter short fall.
// - Event short-circuit bits 2..0 set on debounced high-voltage fault fall.
// - Event timeout bits 3..5 on drop-timeout rise; bits 1..0 on pin events.
// - First fault log records power-down cause bits 5..0.
// - Second fault log records converter timeout and short power-down causes.
// - A mask bit of 1 keeps its event off the interrupt output.
package pse_pkg;
    localparam logic [7:0] PSE_OFS_STATUS_GENERAL = 8'h01;
    localparam logic [7:0] PSE_OFS_STATUS_SHORT_CIRCUIT = 8'h02;
    localparam logic [7:0] PSE_OFS_STATUS_TIMEOUT_PINS = 8'h03;
    localparam logic [7:0] PSE_OFS_EVENT_GENERAL = 8'h04;
    localparam logic [7:0] PSE_OFS_EVENT_SHORT_CIRCUIT = 8'h05;
    localparam logic [7:0] PSE_OFS_EVENT_TIMEOUT_PINS = 8'h06;
    localparam logic [7:0] PSE_OFS_POWERDOWN_CAUSE_LOG = 8'h07;
    localparam logic [7:0] PSE_OFS_POWERDOWN_CAUSE_LOG_CONVERTERS = 8'h08;
    localparam logic [7:0] PSE_RESET_VALUE = 8'h00;
    localparam logic [7:0] PSE_MASK_GENERAL_RESET = 8'h08;
    localparam logic [7:0] PSE_MASK_RESET = 8'h00;
    // Field positions
    localparam int PSE_BIT_EXT_OVERHEAT = 3;
    localparam int PSE_BIT_SEQ = 2;
    localparam int PSE_BIT_JUNCTION = 1;
    localparam int PSE_BIT_SUPPLY = 0;
    localparam int PSE_BIT_CONV_LO = 3;
    localparam int PSE_BIT_HV_LO = 0;
    localparam int PSE_BIT_PIN_LO = 0;
    // Debounce
    localparam int PSE_CLK_MHZ = 200;
    localparam int PSE_DEBOUNCE_US = 10;
    localparam int PSE_DEBOUNCE_CYCLES = PSE_DEBOUNCE_US * PSE_CLK_MHZ;
    localparam int PSE_DEB_W = 12;
endpackage

//--- hdl/pse_status_event.sv
`timescale 1ns/10ps
module pse_status_event (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic external_overheat_flag,
    input wire logic sequencing,
    input wire logic sequence_done,
    input wire logic junction_overheat_flag,
    input wire logic supply_fault,
    input wire logic [2:0] conv_short_flag,
    input wire logic hv_ctrl_short_flag,
    input wire logic hv_ctrl_undervolt_flag,
    input wire logic hv_ctrl_overvolt_flag,
    input wire logic [2:0] conv_drop_timeout_flag,
    input wire logic [1:0] pin_condition_flag,
    input wire logic [1:0] pin_event,
    input wire logic powerdown,
    input wire logic [5:0] powerdown_cause,
    input wire logic [5:0] powerdown_cause_converters,
    input wire logic [7:0] irq_mask_general,
    input wire logic [7:0] irq_mask_short_circuit,
    input wire logic [7:0] irq_mask_timeout_pins,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic interrupt_out_n
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int NIN = 20;
    logic [NIN-1:0] raw;
    logic [NIN-1:0] meta_ff;
    logic [NIN-1:0] sync_ff;
    logic [NIN-1:0] prev_ff;
    assign raw = {pin_event, pin_condition_flag, conv_drop_timeout_flag,
                  hv_ctrl_overvolt_flag, hv_ctrl_undervolt_flag, hv_ctrl_short_flag,
                  conv_short_flag, supply_fault, junction_overheat_flag,
                  sequence_done, sequencing, external_overheat_flag, powerdown,
                  1'b0};
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
            prev_ff <= '0;
        end else begin
            meta_ff <= raw;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end
    // Cause vectors are sampled only on the synchronised power-down edge,
    // by which point they have been stable for two cycles.
    logic pd_s;
    logic pd_rise;
    logic ext_s, seq_s, sdone_s, junc_s, sfault_s;
    logic [5:0] scp_s;
    logic [2:0] tmo_s;
    logic [1:0] pcond_s, pev_s;
    assign pd_s = sync_ff[1];
    assign pd_rise = sync_ff[1] & ~prev_ff[1];
    assign ext_s = sync_ff[2];
    assign seq_s = sync_ff[3];
    assign sdone_s = sync_ff[4];
    assign junc_s = sync_ff[5];
    assign sfault_s = sync_ff[6];
    assign scp_s = {sync_ff[9:7], sync_ff[10], sync_ff[11], sync_ff[12]};
    assign tmo_s = sync_ff[15:13];
    assign pcond_s = sync_ff[17:16];
    assign pev_s = sync_ff[19:18];

    // ------------------------------------------------------------
    // Debounce of short-circuit and hv fault signals
    // ------------------------------------------------------------
    localparam logic [pse_pkg::PSE_DEB_W-1:0] DEB_MAX =
        pse_pkg::PSE_DEB_W'(pse_pkg::PSE_DEBOUNCE_CYCLES - 1);
    logic [5:0] deb_ff;
    logic [5:0] deb_prev_ff;
    logic [pse_pkg::PSE_DEB_W-1:0] deb_cnt_ff [6];
    for (genvar i = 0; i < 6; i++) begin : g_deb
        // Level must hold steady 10 us before the filtered copy follows
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                deb_ff[i] <= 1'b0;
                deb_cnt_ff[i] <= '0;
            end else if (scp_s[i] == deb_ff[i]) begin
                deb_cnt_ff[i] <= '0;
            end else if (deb_cnt_ff[i] == DEB_MAX) begin
                deb_ff[i] <= scp_s[i];
                deb_cnt_ff[i] <= '0;
            end else begin
                deb_cnt_ff[i] <= deb_cnt_ff[i] + 1'b1;
            end
        end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            deb_prev_ff <= '0;
        end else begin
            deb_prev_ff <= deb_ff;
        end
    end

    // ------------------------------------------------------------
    // Event sources
    // ------------------------------------------------------------
    logic [7:0] set_general, set_short, set_tmo;
    logic [7:0] st_general, st_short, st_tmo;
    always_comb begin
        set_general = '0;
        set_general[pse_pkg::PSE_BIT_EXT_OVERHEAT] = ext_s & ~prev_ff[2];
        set_general[pse_pkg::PSE_BIT_SEQ] = sdone_s & ~prev_ff[4];
        set_general[pse_pkg::PSE_BIT_JUNCTION] = junc_s & ~prev_ff[5];
        set_general[pse_pkg::PSE_BIT_SUPPLY] = sfault_s & ~prev_ff[6];
        set_short = {2'b00, deb_prev_ff & ~deb_ff};
        set_tmo = '0;
        set_tmo[pse_pkg::PSE_BIT_CONV_LO +: 3] = tmo_s & ~prev_ff[15:13];
        set_tmo[pse_pkg::PSE_BIT_PIN_LO +: 2] = pev_s & ~prev_ff[19:18];
        st_general = {4'h0, ext_s, seq_s, junc_s, ~sfault_s};
        st_short = {2'b00, scp_s};
        st_tmo = {2'b00, tmo_s, 1'b0, pcond_s};
    end

    // ------------------------------------------------------------
    // Sticky registers, write-one-to-clear, set beats clear
    // ------------------------------------------------------------
    logic [7:0] ev_general_ff, ev_short_ff, ev_tmo_ff, log_ff, log_conv_ff;
    logic [7:0] log_set, log_conv_set;
    assign log_set = pd_rise ? {2'b00, powerdown_cause} : 8'h00;
    assign log_conv_set = pd_rise ? {2'b00, powerdown_cause_converters} : 8'h00;

    function automatic logic [7:0] pse_w1c(input logic [7:0] cur, input logic [7:0] set,
                                           input logic hit, input logic [7:0] wd);
        pse_w1c = (cur & ~(hit ? wd : 8'h00)) | set;
    endfunction

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ev_general_ff <= pse_pkg::PSE_RESET_VALUE;
            ev_short_ff <= pse_pkg::PSE_RESET_VALUE;
            ev_tmo_ff <= pse_pkg::PSE_RESET_VALUE;
            log_ff <= pse_pkg::PSE_RESET_VALUE;
            log_conv_ff <= pse_pkg::PSE_RESET_VALUE;
        end else begin
            ev_general_ff <= pse_w1c(ev_general_ff, set_general,
                reg_wr && reg_addr == pse_pkg::PSE_OFS_EVENT_GENERAL, reg_wdata);
            ev_short_ff <= pse_w1c(ev_short_ff, set_short,
                reg_wr && reg_addr == pse_pkg::PSE_OFS_EVENT_SHORT_CIRCUIT, reg_wdata);
            ev_tmo_ff <= pse_w1c(ev_tmo_ff, set_tmo,
                reg_wr && reg_addr == pse_pkg::PSE_OFS_EVENT_TIMEOUT_PINS, reg_wdata);
            log_ff <= pse_w1c(log_ff, log_set,
                reg_wr && reg_addr == pse_pkg::PSE_OFS_POWERDOWN_CAUSE_LOG, reg_wdata);
            log_conv_ff <= pse_w1c(log_conv_ff, log_conv_set,
                reg_wr && reg_addr == pse_pkg::PSE_OFS_POWERDOWN_CAUSE_LOG_CONVERTERS,
                reg_wdata);
        end
    end

    // ------------------------------------------------------------
    // Read data and interrupt
    // ------------------------------------------------------------
    logic [7:0] nxt_rdata;
    always_comb begin
        unique case (reg_addr)
            pse_pkg::PSE_OFS_STATUS_GENERAL: nxt_rdata = st_general;
            pse_pkg::PSE_OFS_STATUS_SHORT_CIRCUIT: nxt_rdata = st_short;
            pse_pkg::PSE_OFS_STATUS_TIMEOUT_PINS: nxt_rdata = st_tmo;
            pse_pkg::PSE_OFS_EVENT_GENERAL: nxt_rdata = ev_general_ff;
            pse_pkg::PSE_OFS_EVENT_SHORT_CIRCUIT: nxt_rdata = ev_short_ff;
            pse_pkg::PSE_OFS_EVENT_TIMEOUT_PINS: nxt_rdata = ev_tmo_ff;
            pse_pkg::PSE_OFS_POWERDOWN_CAUSE_LOG: nxt_rdata = log_ff;
            pse_pkg::PSE_OFS_POWERDOWN_CAUSE_LOG_CONVERTERS: nxt_rdata = log_conv_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end
    logic nxt_irq_n;
    // Fault logs are not events, so they never raise the interrupt
    assign nxt_irq_n = ~(|(ev_general_ff & ~irq_mask_general[7:0])
                       | |(ev_short_ff & ~irq_mask_short_circuit)
                       | |(ev_tmo_ff & ~irq_mask_timeout_pins));
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
            interrupt_out_n <= 1'b1;
        end else begin
            reg_rdata <= nxt_rdata;
            interrupt_out_n <= nxt_irq_n;
        end
    end
    logic unused_pd;
    assign unused_pd = pd_s ^ sync_ff[0];
endmodule

//--- tb/pse_host_model.sv
`timescale 1ns/10ps
module pse_host_model (
    input wire logic mclk,
    input wire logic [7:0] reg_rdata,
    input wire logic interrupt_out_n,
    output logic reg_wr,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    logic [8:0] exp_q[$];
    logic [8:0] e;
    logic rq = 1'b0;
    logic rq_ff = 1'b0;
    int n_mismatch = 0;
    int checked = 0;
    initial {reg_wr, reg_addr, reg_wdata} = 17'h0;
    // One bus cycle; x[8] selects an interrupt check instead of read data
    task automatic cyc(input logic w, input logic [7:0] a, input logic [7:0] d,
                       input logic c, input logic [8:0] x);
        reg_wr <= w;
        reg_addr <= a;
        reg_wdata <= d;
        rq <= c;
        if (c) exp_q.push_back(x);
        @(posedge mclk);
    endtask
    always @(posedge mclk) rq_ff <= rq;
    // Negedge compare: read data lands one edge after the address
    always @(negedge mclk) begin
        if (rq_ff) begin
            e = exp_q.pop_front();
            checked++;
            if (e[8] ? interrupt_out_n !== e[0] : reg_rdata !== e[7:0]) begin
                n_mismatch++;
                $display("ERROR %s expected %h seen %h", e[8] ? "interrupt_out_n" : "reg_rdata",
                         e[7:0], e[8] ? {7'h0, interrupt_out_n} : reg_rdata);
            end
        end
    end
endmodule

//--- tb/pse_monitor.sv
`timescale 1ns/10ps
module pse_monitor (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic supply_fault,
    input wire logic junction_overheat_flag,
    input wire logic [7:0] irq_mask_general,
    input wire logic [7:0] irq_mask_short_circuit,
    input wire logic [7:0] irq_mask_timeout_pins,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic interrupt_out_n
);
    logic [2:0] up_ff;
    logic quiet;
    assign quiet = &{irq_mask_general, irq_mask_short_circuit, irq_mask_timeout_pins};
    // Sync flops still hold reset values for a few cycles
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) up_ff <= 3'h0;
        else if (up_ff != 3'h7) up_ff <= up_ff + 3'h1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_general_high_zero: assert property ((reg_addr == 8'h01 || reg_addr == 8'h04)
        |=> reg_rdata[7:4] == 4'h0) else $error("general register high bits set");
    a_pins_reserved_zero: assert property ((reg_addr == 8'h03 || reg_addr == 8'h06)
        |=> reg_rdata[7:6] == 2'h0 && !reg_rdata[2]) else $error("pin register reserved bits set");
    a_short_reserved_zero: assert property ((reg_addr == 8'h02 || reg_addr == 8'h05)
        |=> reg_rdata[7:6] == 2'h0) else $error("short register reserved bits set");
    a_supply_inverse: assert property ((up_ff == 3'h7 && $stable(supply_fault)) [*4]
        ##0 reg_addr == 8'h01 |=> reg_rdata[0] == !$past(supply_fault))
        else $error("supply status not inverted level");
    a_junction_live: assert property ((up_ff == 3'h7 && $stable(junction_overheat_flag)) [*4]
        ##0 reg_addr == 8'h01 |=> reg_rdata[1] == $past(junction_overheat_flag))
        else $error("junction status not live");
    a_masked_no_irq: assert property (quiet [*2] |-> interrupt_out_n)
        else $error("interrupt while all masked");
    a_reset_idle: assert property ($rose(reset_n) |-> interrupt_out_n && reg_rdata == 8'h00)
        else $error("outputs not idle after reset");
    a_supply_event_irq: assert property ((up_ff == 3'h7 && $rose(supply_fault)
        && !irq_mask_general[0]) ##1 !irq_mask_general[0] [*5] |-> !interrupt_out_n)
        else $error("supply drop gave no interrupt");
endmodule
bind pse_status_event pse_monitor i_pse_monitor (.mclk, .reset_n, .supply_fault,
    .junction_overheat_flag, .irq_mask_general, .irq_mask_short_circuit,
    .irq_mask_timeout_pins, .reg_addr, .reg_rdata, .interrupt_out_n);

//--- tb/tb_pse_status_event.sv
`timescale 1ns/10ps
module tb_pse_status_event;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic external_overheat_flag, sequencing, sequence_done, junction_overheat_flag, supply_fault;
    logic hv_ctrl_short_flag, hv_ctrl_undervolt_flag, hv_ctrl_overvolt_flag, powerdown;
    logic [2:0] conv_short_flag, conv_drop_timeout_flag;
    logic [1:0] pin_condition_flag, pin_event;
    logic [5:0] powerdown_cause, powerdown_cause_converters;
    logic [7:0] irq_mask_general, irq_mask_short_circuit, irq_mask_timeout_pins;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, interrupt_out_n;
    logic [31:0] v;
    pse_status_event i_pse_status_event (.mclk, .reset_n, .external_overheat_flag, .sequencing,
        .sequence_done, .junction_overheat_flag, .supply_fault, .conv_short_flag,
        .hv_ctrl_short_flag, .hv_ctrl_undervolt_flag, .hv_ctrl_overvolt_flag,
        .conv_drop_timeout_flag, .pin_condition_flag, .pin_event, .powerdown, .powerdown_cause,
        .powerdown_cause_converters, .irq_mask_general, .irq_mask_short_circuit,
        .irq_mask_timeout_pins, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .interrupt_out_n);
    pse_host_model i_host (.mclk, .reg_rdata, .interrupt_out_n, .reg_wr, .reg_addr, .reg_wdata);
    task automatic flags(input logic [31:0] f);
        {external_overheat_flag, sequencing, sequence_done, junction_overheat_flag} <= f[4:1];
        supply_fault <= f[0];
        {conv_short_flag, hv_ctrl_short_flag, hv_ctrl_undervolt_flag, hv_ctrl_overvolt_flag} <= f[10:5];
        {conv_drop_timeout_flag, pin_condition_flag, pin_event} <= f[17:11];
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.cyc(1'b1, a, d, 1'b0, 9'h000);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_host.cyc(1'b0, a, 8'h00, 1'b1, {1'b0, e});
    endtask
    task automatic irq(input logic e);
        i_host.cyc(1'b0, 8'h00, 8'h00, 1'b1, {8'h80, e});
    endtask
    task automatic idle(input int n);
        repeat (n) i_host.cyc(1'b0, 8'h00, 8'h00, 1'b0, 9'h000);
    endtask
    task automatic stop_test;
        if (i_host.n_mismatch == 0 && i_host.checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial forever #2.5 mclk = ~mclk;
    initial begin
        repeat (20000) @(posedge mclk);
        i_host.n_mismatch++;
        stop_test;
    end
    initial begin
        void'($urandom(32'h40b1e9a2));
        flags(32'h0);
        {powerdown, powerdown_cause, powerdown_cause_converters} <= 13'h0;
        {irq_mask_general, irq_mask_short_circuit, irq_mask_timeout_pins} <= 24'hffffff;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        idle(4);
        wr(8'h01, 8'hff);
        irq(1'b1);
        for (int a = 0; a < 10; a++) rd(a[7:0], (a == 1) ? 8'h01 : 8'h00);
        repeat (4) begin
            v = $urandom;
            flags(v);
            idle(5);
            rd(8'h01, {4'h0, v[4], v[3], v[1], ~v[0]});
            rd(8'h02, {2'h0, v[10:5]});
            rd(8'h03, {2'h0, v[17:15], 1'b0, v[14:13]});
        end
        flags(32'h0);
        idle(2020);
        for (int a = 4; a < 7; a++) wr(a[7:0], 8'hff);
        irq_mask_general <= 8'hfe;
        flags(32'h3ffff);
        idle(5);
        rd(8'h04, 8'h0f);
        rd(8'h06, 8'h3b);
        irq(1'b0);
        // Shorts must first settle high through the filter, or no fall exists
        idle(2010);
        flags(32'h0);
        idle(1990);
        rd(8'h05, 8'h00);
        idle(20);
        rd(8'h05, 8'h3f);
        wr(8'h04, 8'h00);
        rd(8'h04, 8'h0f);
        wr(8'h04, 8'h05);
        rd(8'h04, 8'h0a);
        irq(1'b1);
        irq_mask_short_circuit <= 8'hf7;
        idle(2);
        irq(1'b0);
        wr(8'h05, 8'hff);
        irq_mask_timeout_pins <= 8'hfd;
        idle(2);
        irq(1'b0);
        wr(8'h06, 8'h3b);
        wr(8'h04, 8'h0a);
        rd(8'h06, 8'h00);
        idle(2);
        irq(1'b1);
        {irq_mask_general, irq_mask_short_circuit, irq_mask_timeout_pins} <= 24'h0;
        v = $urandom;
        {powerdown, powerdown_cause, powerdown_cause_converters} <= {1'b1, v[11:0]};
        idle(4);
        rd(8'h07, {2'h0, v[11:6]});
        rd(8'h08, {2'h0, v[5:0]});
        irq(1'b1);
        wr(8'h07, 8'hff);
        rd(8'h07, 8'h00);
        rd(8'h08, {2'h0, v[5:0]});
        stop_test;
    end
endmodule
